// ---- core/combo_cell.sv ----
// One table-or-storage cell with optional clear/preset and dual-edge mode
`timescale 1ns/1ps
`default_nettype none
module combo_cell #(
	parameter int N_IN      = 2,
	parameter bit HAS_CLEAR = 1'b0
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [N_IN-1:0]      ins,
	input  wire logic [2**N_IN-1:0]   truth,
	input  wire logic                 store_mode,
	input  wire logic                 latch_mode,
	input  wire logic                 clear_low,
	input  wire logic                 preset,
	input  wire logic                 dual_mode,
	output var  logic                 q
);

	// ==========================================================
	// State
	logic       q_reg;
	logic       q_next;
	logic       ck_prev_reg;
	logic       ck_prev_next;
	logic       hold_reg;
	logic       hold_next;
	logic [2:0] x;
	logic       rise;
	logic       fall;
	logic       rs_act;

	// Pad inputs so the two-input form shares the same decode
	always_comb begin
		x = 3'h0;
		x[N_IN-1:0] = ins;
	end

	// Edges of the matrix clock are seen in the system clock domain
	assign rise = x[0] & ~ck_prev_reg;
	assign fall = ~x[0] & ck_prev_reg;
	// Polarity bit 1 means the clear/preset input acts when low
	assign rs_act = HAS_CLEAR && (clear_low ? ~x[2] : x[2]); // R10

	// Next state: table, clear/preset, latch, dual-edge or plain flop
	always_comb begin
		q_next = q_reg;
		hold_next = hold_reg;
		ck_prev_next = x[0];
		if (!store_mode) begin
			q_next = truth[ins]; // R1 R2 R4 R5 R6 R15 R16
		end else if (rs_act) begin
			q_next = preset; // R14
			hold_next = preset;
		end else if (latch_mode) begin
			if (!x[0]) begin
				q_next = x[1]; // R8
			end
		end else if (dual_mode) begin
			if (rise) begin
				hold_next = x[1]; // R9
			end
			if (fall) begin
				q_next = hold_reg; // R9
			end
		end else if (rise) begin
			q_next = x[1]; // R7 R13
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q_reg <= 1'b0;
			hold_reg <= 1'b0;
			ck_prev_reg <= 1'b0;
		end else begin
			q_reg <= q_next;
			hold_reg <= hold_next;
			ck_prev_reg <= ck_prev_next;
		end
	end

	assign q = q_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence plain_rise_s;
		store_mode && !rs_act && !latch_mode && !dual_mode && rise;
	endsequence

	table_out_a: assert property (!store_mode |=> q_reg == $past(truth[ins])) // R4
		else $error("table output does not match truth bit");
	flop_capture_a: assert property (plain_rise_s ##0 1'b1 |=> q_reg == $past(x[1])) // R7
		else $error("flop missed data on rising edge");
	flop_hold_a: assert property (store_mode && !latch_mode && !rs_act && !rise
		&& !dual_mode |=> $stable(q_reg)) // R7
		else $error("flop output moved without rising edge");
	latch_pass_a: assert property (store_mode && latch_mode && !rs_act && !x[0]
		|=> q_reg == $past(x[1])) // R8
		else $error("latch not transparent while clock low");
	dual_present_a: assert property (store_mode && dual_mode && !latch_mode && !rs_act
		&& fall |=> q_reg == $past(hold_reg)) // R9
		else $error("dual mode did not present on falling edge");
	clear_force_a: assert property (store_mode && rs_act ##1 store_mode && rs_act
		|=> q_reg == $past(preset, 2)) // R10
		else $error("clear or preset not applied");

endmodule
`default_nettype wire

// ---- core/combo_cells_top.sv ----
// Combination function cells with emitter, virtual inputs and readback
`timescale 1ns/1ps
`default_nettype none
module combo_cells_top #(
	parameter int PATTERN_LEN = combo_pkg::PATTERN_MAX
) (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire combo_pkg::cfg_t             cfg,
	input  wire combo_pkg::matrix_in_t       matrix_in,
	input  wire logic [combo_pkg::VIN_WIDTH-1:0] vin_init,
	input  wire logic                        rb_wr,
	input  wire logic [combo_pkg::RB_WIDTH-1:0]  rb_wr_data,
	output var  combo_pkg::matrix_out_t      matrix_out,
	output var  logic [combo_pkg::VIN_WIDTH-1:0] vin_out,
	output var  logic [combo_pkg::RB_WIDTH-1:0]  readback
);

	// ==========================================================
	// Reset release through two flops
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ==========================================================
	// Matrix inputs come from other clocks and pins: two-flop sync
	combo_pkg::matrix_in_t in_meta_reg;
	combo_pkg::matrix_in_t in_sync_reg;

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			in_meta_reg <= '0;
			in_sync_reg <= '0;
		end else begin
			in_meta_reg <= matrix_in;
			in_sync_reg <= in_meta_reg;
		end
	end

	// ==========================================================
	// Configuration image: loaded once, then frozen until next reset
	combo_pkg::cfg_t            cfg_reg;
	combo_pkg::cfg_t            cfg_next;
	logic                       loaded_reg;
	logic                       loaded_next;
	logic [combo_pkg::VIN_WIDTH-1:0] vin_reg;
	logic [combo_pkg::VIN_WIDTH-1:0] vin_next;

	// Freezing the image keeps each cell's function stable in operation
	always_comb begin
		cfg_next = cfg_reg;
		loaded_next = 1'b1;
		vin_next = vin_reg;
		if (!loaded_reg) begin
			cfg_next = cfg; // R20
			vin_next = vin_init; // R19
		end else if (rb_wr) begin
			vin_next = rb_wr_data[combo_pkg::VIN_POS +: combo_pkg::VIN_WIDTH]; // R18 R19
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			cfg_reg <= '0;
			loaded_reg <= 1'b0;
			vin_reg <= combo_pkg::VIN_RESET;
		end else begin
			cfg_reg <= cfg_next;
			loaded_reg <= loaded_next;
			vin_reg <= vin_next;
		end
	end

	// ==========================================================
	// Storage-capable cells; cells stay cleared until the image is in
	logic cell_rst_n;
	logic q_t2_zero;
	logic q_t2_one;
	logic q_t3_zero;
	logic q_t3_two;
	logic q_t3_three;

	assign cell_rst_n = rst_sync_reg & loaded_reg;

	combo_cell #(.N_IN(2), .HAS_CLEAR(1'b0)) u_table_cell_zero (
		.clk        (clk),
		.rst_n      (cell_rst_n),
		.ins        (in_sync_reg.t2_zero),
		.truth      (cfg_reg.t2_zero_truth),
		.store_mode (cfg_reg.store_sel[0]),
		.latch_mode (cfg_reg.latch_sel[0]),
		.clear_low  (1'b0),
		.preset     (1'b0),
		.dual_mode  (1'b0),
		.q          (q_t2_zero)
	);

	combo_cell #(.N_IN(2), .HAS_CLEAR(1'b0)) u_table_cell_one (
		.clk        (clk),
		.rst_n      (cell_rst_n),
		.ins        (in_sync_reg.t2_one),
		.truth      (cfg_reg.t2_one_truth),
		.store_mode (cfg_reg.store_sel[1]),
		.latch_mode (cfg_reg.latch_sel[1]),
		.clear_low  (1'b0),
		.preset     (1'b0),
		.dual_mode  (1'b0),
		.q          (q_t2_one)
	);

	// Only this three-input cell offers the dual-edge mode
	combo_cell #(.N_IN(3), .HAS_CLEAR(1'b1)) u_dual_edge_capable_flop (
		.clk        (clk),
		.rst_n      (cell_rst_n),
		.ins        (in_sync_reg.t3_zero),
		.truth      (cfg_reg.t3_zero_truth),
		.store_mode (cfg_reg.store_sel[2]),
		.latch_mode (cfg_reg.latch_sel[2]),
		.clear_low  (cfg_reg.clear_low[0]),
		.preset     (cfg_reg.preset_sel[0]),
		.dual_mode  (cfg_reg.dual_edge),
		.q          (q_t3_zero)
	);

	combo_cell #(.N_IN(3), .HAS_CLEAR(1'b1)) u_table_cell_two (
		.clk        (clk),
		.rst_n      (cell_rst_n),
		.ins        (in_sync_reg.t3_two),
		.truth      (cfg_reg.t3_two_truth),
		.store_mode (cfg_reg.store_sel[3]),
		.latch_mode (cfg_reg.latch_sel[3]),
		.clear_low  (cfg_reg.clear_low[1]),
		.preset     (cfg_reg.preset_sel[1]),
		.dual_mode  (1'b0),
		.q          (q_t3_two)
	);

	combo_cell #(.N_IN(3), .HAS_CLEAR(1'b1)) u_table_cell_three (
		.clk        (clk),
		.rst_n      (cell_rst_n),
		.ins        (in_sync_reg.t3_three),
		.truth      (cfg_reg.t3_three_truth),
		.store_mode (cfg_reg.store_sel[4]),
		.latch_mode (cfg_reg.latch_sel[4]),
		.clear_low  (cfg_reg.clear_low[2]),
		.preset     (cfg_reg.preset_sel[2]),
		.dual_mode  (1'b0),
		.q          (q_t3_three)
	);

	// ==========================================================
	// Table-or-emitter cell: in0 is the clock, in1 the emitter reset
	logic [3:0] idx_reg;
	logic [3:0] idx_next;
	logic       emit_reg;
	logic       emit_next;
	logic       ck_prev_reg;
	logic       ck_prev_next;
	logic [3:0] last_idx;
	logic       emit_rise;
	logic       emit_rst;

	// Lengths below two are raised to two; one-bit patterns do not exist
	assign last_idx = (cfg_reg.pattern_len_m1 < combo_pkg::MIN_LEN_M1) ?
		combo_pkg::MIN_LEN_M1 : cfg_reg.pattern_len_m1; // R12
	assign emit_rise = in_sync_reg.t2_two[0] & ~ck_prev_reg;
	assign emit_rst = cfg_reg.emit_rst_low ? ~in_sync_reg.t2_two[1]
		: in_sync_reg.t2_two[1]; // R11

	always_comb begin
		idx_next = idx_reg;
		emit_next = emit_reg;
		ck_prev_next = in_sync_reg.t2_two[0];
		if (!cfg_reg.emit_sel) begin
			emit_next = cfg_reg.t2_two_truth[in_sync_reg.t2_two]; // R3 R15
			idx_next = 4'h0;
		end else if (emit_rst) begin
			emit_next = 1'b0; // R11
			idx_next = 4'h0;
		end else if (emit_rise) begin
			emit_next = cfg_reg.pattern[idx_reg]; // R12
			idx_next = (idx_reg >= last_idx) ? 4'h0 : idx_reg + 4'h1; // R12
		end
	end

	always_ff @(posedge clk or negedge cell_rst_n) begin
		if (!cell_rst_n) begin
			idx_reg <= 4'h0;
			emit_reg <= 1'b0;
			ck_prev_reg <= 1'b0;
		end else begin
			idx_reg <= idx_next;
			emit_reg <= emit_next;
			ck_prev_reg <= ck_prev_next;
		end
	end

	// ==========================================================
	// Readback image: live cell outputs plus virtual inputs, one cycle late
	logic [combo_pkg::RB_WIDTH-1:0] rb_reg;
	logic [combo_pkg::RB_WIDTH-1:0] rb_next;

	always_comb begin
		rb_next = '0;
		rb_next[combo_pkg::RB_POS_T2_ZERO] = q_t2_zero; // R17
		rb_next[combo_pkg::RB_POS_T2_ONE] = q_t2_one;
		rb_next[combo_pkg::RB_POS_T2_TWO] = emit_reg;
		rb_next[combo_pkg::RB_POS_T3_ZERO] = q_t3_zero;
		rb_next[combo_pkg::RB_POS_T3_TWO] = q_t3_two;
		rb_next[combo_pkg::RB_POS_T3_THREE] = q_t3_three;
		rb_next[combo_pkg::VIN_POS +: combo_pkg::VIN_WIDTH] = vin_reg; // R19
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rb_reg <= '0;
		end else begin
			rb_reg <= rb_next;
		end
	end

	// Outputs straight from flops
	assign matrix_out.t2_zero = q_t2_zero;
	assign matrix_out.t2_one = q_t2_one;
	assign matrix_out.t2_two = emit_reg;
	assign matrix_out.t3_zero = q_t3_zero;
	assign matrix_out.t3_two = q_t3_two;
	assign matrix_out.t3_three = q_t3_three;
	assign vin_out = vin_reg;
	assign readback = rb_reg;

	// ==========================================================
	// Checks
	vin_write_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
		loaded_reg && rb_wr |=> vin_out == $past(rb_wr_data[39:32])
		##1 readback[39:32] == $past(rb_wr_data[39:32], 2)) // R19
		else $error("virtual input write not applied");
	readback_ro_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
		readback[63:40] == 24'h0 && readback[31:11] == 21'h0) // R18
		else $error("write leaked into read-only readback bits");
	emit_wrap_a: assert property (@(posedge clk) disable iff (!cell_rst_n)
		cfg_reg.emit_sel && !emit_rst && emit_rise && idx_reg >= last_idx
		|=> idx_reg == 4'h0) // R12
		else $error("emitter did not wrap at programmed length");
	cfg_fixed_a: assert property (@(posedge clk) disable iff (!rst_sync_reg)
		loaded_reg |=> $stable(cfg_reg)) // R20
		else $error("configuration changed during operation");

endmodule
`default_nettype wire

// ---- shared/combo_pkg.sv ----
// Shared types and constants for the combination function cells
// Notes on behaviour
// [R1] Two-input cell zero outputs its indexed truth bit
// [R2] Two-input cell one outputs its indexed truth bit
// [R3] Emitter-capable cell in table mode indexes truth bits
// [R4] Three-input cell zero outputs indexed truth bit
// [R5] Three-input cell two outputs indexed truth bit
// [R6] Three-input cell three outputs indexed truth bit
// [R7] Flop mode captures data on clock rise only
// [R8] Latch mode is transparent while clock low
// [R9] Dual mode: capture on rise, present on fall
// [R10] Each three-input cell picks clear/preset polarity
// [R11] Emitter reset polarity chosen by configuration bit
// [R12] Emitter repeats programmed sequence, two to sixteen bits
// [R13] Two-input storage uses inputs as clock, data
// [R14] Three-input storage uses clock, data, clear/preset
// [R15] Two-input tables realise standard gates
// [R16] Three-input tables realise standard gates
// [R17] Every cell output readable in readback range
// [R18] Readback writes ignored except virtual input bits
// [R19] Virtual input write drives matrix; read returns value
// [R20] Cell function is fixed once configured
package combo_pkg;

	// ==========================================================
	// Readback map
	localparam int RB_BASE_ADDR     = 576;
	localparam int RB_WIDTH         = 64;
	localparam int VIN_BASE_ADDR    = 608;
	localparam int VIN_WIDTH        = 8;
	localparam int VIN_POS          = VIN_BASE_ADDR - RB_BASE_ADDR;
	localparam int RB_POS_T2_ZERO   = 1;
	localparam int RB_POS_T2_ONE    = 2;
	localparam int RB_POS_T2_TWO    = 4;
	localparam int RB_POS_T3_ZERO   = 5;
	localparam int RB_POS_T3_TWO    = 9;
	localparam int RB_POS_T3_THREE  = 10;

	// ==========================================================
	// Cell sizes and reset values
	localparam int PATTERN_MAX      = 16;
	localparam int CELL_CNT         = 5;
	localparam logic [7:0] VIN_RESET = 8'h00;
	localparam logic [3:0] MIN_LEN_M1 = 4'h1;

	// Configuration image, loaded once after reset
	typedef struct packed {
		logic [3:0]             t2_zero_truth;
		logic [3:0]             t2_one_truth;
		logic [3:0]             t2_two_truth;
		logic [7:0]             t3_zero_truth;
		logic [7:0]             t3_two_truth;
		logic [7:0]             t3_three_truth;
		logic [CELL_CNT-1:0]    store_sel;
		logic [CELL_CNT-1:0]    latch_sel;
		logic [2:0]             clear_low;
		logic [2:0]             preset_sel;
		logic                   dual_edge;
		logic                   emit_sel;
		logic                   emit_rst_low;
		logic [PATTERN_MAX-1:0] pattern;
		logic [3:0]             pattern_len_m1;
	} cfg_t;

	// Matrix signals feeding the cells: in0 clock, in1 data (emitter reset on t2_two), in2 clear
	typedef struct packed {
		logic [1:0] t2_zero;
		logic [1:0] t2_one;
		logic [1:0] t2_two;
		logic [2:0] t3_zero;
		logic [2:0] t3_two;
		logic [2:0] t3_three;
	} matrix_in_t;

	// Cell outputs returned to the matrix
	typedef struct packed {
		logic t2_zero;
		logic t2_one;
		logic t2_two;
		logic t3_zero;
		logic t3_two;
		logic t3_three;
	} matrix_out_t;

endpackage

// ---- verif/matrix_partner.sv ----
// Routing matrix model: steady levels from the bench plus a slow emitter clock
`timescale 1ns/1ps
`default_nettype none
module matrix_partner #(
	parameter int HALF = 8
) (
	input  wire logic                  clk,
	input  wire logic                  run,
	input  wire combo_pkg::matrix_in_t req,
	output var  combo_pkg::matrix_in_t matrix_in
);
	// ==========================================================
	// Slow cell clock
	logic [7:0] cnt_reg;
	logic       slow_reg;

	// Half period far above the sync depth, so no cell edge is lost
	always @(posedge clk) begin
		if (!run) begin
			cnt_reg <= 8'h00;
			slow_reg <= 1'b0;
		end else if (cnt_reg == 8'(HALF - 1)) begin
			cnt_reg <= 8'h00;
			slow_reg <= ~slow_reg;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// Bench levels pass through, except the emitter clock while running
	always_comb begin
		matrix_in = req;
		if (run) begin
			matrix_in.t2_two[0] = slow_reg;
		end
	end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the combination function cells
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                   clk;
	logic                   resetn;
	combo_pkg::cfg_t        cfg;
	combo_pkg::cfg_t        c;
	combo_pkg::matrix_in_t  req;
	combo_pkg::matrix_in_t  matrix_in;
	combo_pkg::matrix_out_t matrix_out;
	logic                   emit_run;
	logic                   rl;
	logic                   p;
	logic [7:0]             vin_init;
	logic [7:0]             vin_out;
	logic                   rb_wr;
	logic [63:0]            rb_wr_data;
	logic [63:0]            readback;
	logic [3:0]             g2 [3];
	logic [7:0]             g3 [3];
	logic [7:0]             st [3][5];
	int                     n_errors;
	int                     samples_checked;
	int                     k;
	int                     len;

	combo_cells_top combo_cells_top_i (
		.clk        (clk),
		.resetn     (resetn),
		.cfg        (cfg),
		.matrix_in  (matrix_in),
		.vin_init   (vin_init),
		.rb_wr      (rb_wr),
		.rb_wr_data (rb_wr_data),
		.matrix_out (matrix_out),
		.vin_out    (vin_out),
		.readback   (readback)
	);

	matrix_partner matrix_partner_i (
		.clk       (clk),
		.run       (emit_run),
		.req       (req),
		.matrix_in (matrix_in)
	);

	// 125 MHz clock
	always #4 clk = ~clk;

	// ==========================================================
	// Access tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Outputs and their readback copies must agree with the same expectation
	task automatic chk_cells(input logic [5:0] exp);
		chk("cell outputs", 64'(matrix_out), 64'(exp));
		chk("cell readback", 64'({readback[combo_pkg::RB_POS_T2_ZERO],
			readback[combo_pkg::RB_POS_T2_ONE], readback[combo_pkg::RB_POS_T2_TWO],
			readback[combo_pkg::RB_POS_T3_ZERO], readback[combo_pkg::RB_POS_T3_TWO],
			readback[combo_pkg::RB_POS_T3_THREE]}), 64'(exp));
	endtask

	// Configuration is scrambled after load, so a design that keeps reading it fails
	task automatic do_reset(input combo_pkg::cfg_t cc, input logic [7:0] vi);
		resetn = 1'b0;
		cfg = cc;
		vin_init = vi;
		tick(3);
		resetn = 1'b1;
		tick(6);
		cfg = combo_pkg::cfg_t'(~cc);
		vin_init = ~vi;
	endtask

	task automatic step(input logic ck, input logic d, input logic cl, input logic [5:0] exp);
		req = '{{d, ck}, {d, ck}, {1'b0, ck}, {cl, d, ck}, {cl, d, ck}, {cl, d, ck}};
		tick(5);
		chk_cells(exp);
	endtask

	task automatic wait_in0(input logic v);
		for (int t = 0; t < 40 && matrix_in.t2_two[0] !== v; t++) tick(1);
		if (matrix_in.t2_two[0] !== v) begin
			n_errors++;
			$display("wrong value emitter clock expected %b seen %b", v, matrix_in.t2_two[0]);
			final_report();
		end
	endtask

	task automatic vin_write(input logic [63:0] data);
		rb_wr = 1'b1;
		rb_wr_data = data;
		tick(1);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		clk = 1'b0;
		resetn = 1'b0;
		cfg = '0;
		req = '0;
		emit_run = 1'b0;
		vin_init = 8'h00;
		rb_wr = 1'b0;
		rb_wr_data = 64'h0000_0000_0000_0000;
		n_errors = 0;
		samples_checked = 0;
		g2 = '{4'h8, 4'h1, 4'h6};
		g3 = '{8'h80, 8'hFE, 8'h96};
		st = '{'{8'h40, 8'hF7, 8'hB7, 8'h37, 8'h80},
			'{8'hC0, 8'h77, 8'hF7, 8'hB7, 8'h00},
			'{8'h40, 8'hF3, 8'h37, 8'h84, 8'h00}};
		tick(1);

		// Truth tables with standard gates, every input code
		for (int g = 0; g < 3; g++) begin
			c = '0;
			c.t2_zero_truth = g2[g];
			c.t2_one_truth = g2[(g + 1) % 3];
			c.t2_two_truth = g2[(g + 2) % 3];
			c.t3_zero_truth = g3[g];
			c.t3_two_truth = g3[(g + 1) % 3];
			c.t3_three_truth = g3[(g + 2) % 3];
			do_reset(c, 8'h00);
			for (int i = 0; i < 8; i++) begin
				req = '{i[1:0], i[1:0], i[1:0], i[2:0], i[2:0], i[2:0]};
				tick(5);
				chk_cells({c.t2_zero_truth[i[1:0]], c.t2_one_truth[i[1:0]],
					c.t2_two_truth[i[1:0]], c.t3_zero_truth[i[2:0]],
					c.t3_two_truth[i[2:0]], c.t3_three_truth[i[2:0]]});
			end
		end
		$display("test tables done");

		// Flop, latch and dual-edge storage
		for (int m = 0; m < 3; m++) begin
			c = '0;
			c.store_sel = 5'h1F;
			c.latch_sel = (m == 1) ? 5'h1F : 5'h00;
			req = '0; // Clock low, else the first enabled cycle sees a stale rise
			c.clear_low = 3'h7;
			c.dual_edge = (m == 2);
			do_reset(c, 8'h00);
			for (int s = 0; s < 5; s++) begin
				step(st[m][s][7], st[m][s][6], 1'b1, st[m][s][5:0]);
			end
		end
		$display("test storage done");

		// Clear with its input active high, then preset with its input active low
		for (int pol = 0; pol < 2; pol++) begin
			p = pol[0];
			c = '0;
			c.store_sel = 5'h1F;
			c.clear_low = {3{p}};
			c.preset_sel = {3{p}};
			req = '0; // Clock and clear low, so the start state follows polarity
			do_reset(c, 8'h00);
			step(1'b0, ~p, p, {3'b000, {3{p}}});
			step(1'b1, ~p, p, {~p, ~p, 1'b0, {3{~p}}});
			step(1'b1, ~p, ~p, {~p, ~p, 1'b0, {3{p}}});
		end
		$display("test clear done");

		// Emitter: lengths 16, 3 and 2, both reset polarities, reset mid-run
		for (int e = 0; e < 3; e++) begin
			c = '0;
			c.emit_sel = 1'b1;
			c.emit_rst_low = (e != 1);
			c.pattern = 16'hC5A3;
			c.pattern_len_m1 = (e == 0) ? 4'hF : ((e == 1) ? 4'h2 : 4'h0);
			len = ((c.pattern_len_m1 < 4'h1) ? 1 : int'(c.pattern_len_m1)) + 1;
			rl = c.emit_rst_low;
			req = '0;
			req.t2_two[1] = rl;
			emit_run = 1'b0;
			do_reset(c, 8'h00);
			emit_run = 1'b1;
			k = 0;
			for (int n = 0; n < len + 6; n++) begin
				wait_in0(1'b0);
				req.t2_two[1] = (n == len + 3) ? ~rl : rl;
				wait_in0(1'b1);
				tick(5);
				if (n == len + 3) begin
					chk("emitter in reset", 64'(matrix_out.t2_two), 64'h0);
					k = 0;
				end else begin
					chk("emitter output", 64'(matrix_out.t2_two), 64'(c.pattern[k % len]));
					k++;
				end
			end
			emit_run = 1'b0;
		end
		$display("test emitter done");

		// Virtual inputs: startup value, single and back-to-back writes
		c = '0;
		c.t3_three_truth = 8'hFF;
		req = '0;
		do_reset(c, 8'hA5);
		chk("virtual out", 64'(vin_out), 64'hA5);
		chk("virtual readback", 64'(readback[combo_pkg::VIN_POS +: 8]), 64'hA5);
		vin_write(64'hFFFF_FF3C_FFFF_FFFF);
		rb_wr = 1'b0;
		tick(3);
		chk("virtual out", 64'(vin_out), 64'h3C);
		chk_cells(6'b000001);
		vin_write(64'h0000_0011_0000_0000);
		chk("virtual out", 64'(vin_out), 64'h11);
		vin_write(64'h0000_00C6_0000_0000);
		rb_wr = 1'b0;
		tick(3);
		chk("virtual out", 64'(vin_out), 64'hC6);
		chk("virtual readback", 64'(readback[combo_pkg::VIN_POS +: 8]), 64'hC6);
		$display("test virtual inputs done");
		final_report();
	end
endmodule
`default_nettype wire
